//--- hdl/tma_params.svh
`ifndef TMA_PARAMS_SVH
`define TMA_PARAMS_SVH

// Register byte offsets
`define TMA_A_CMD 8'h00
`define TMA_A_FUNC 8'h04
`define TMA_A_SRC 8'h08
`define TMA_A_LEVEL 8'h0C
`define TMA_A_HYSTERESIS_BAND 8'h10
`define TMA_A_SLOPE 8'h14
`define TMA_A_COUNT 8'h18
`define TMA_A_POINTS 8'h1C
`define TMA_A_OFFSET 8'h20
`define TMA_A_PERIOD 8'h24
`define TMA_A_OPER 8'h28
`define TMA_A_QUES 8'h2C
`define TMA_A_ESR 8'h30
`define TMA_A_FETCH 8'h34
`define TMA_A_BUFIDX 8'h38
`define TMA_A_BUFDATA 8'h3C

// Command register bits
`define TMA_CMD_ARM 0
`define TMA_CMD_ABORT 1
`define TMA_CMD_IMM 2
`define TMA_CMD_TRG 3
`define TMA_CMD_GET 4
`define TMA_CMD_OPC 5
`define TMA_CMD_FETCH 6
`define TMA_CMD_RESET 7

// Status bit positions
`define TMA_OPER_WTG 5
`define TMA_QUES_OVLD 14
`define TMA_ESR_OPC 0
`define TMA_ESR_EXE 4

// Limits and reset values
`define TMA_BUF_DEPTH 4096
`define TMA_OFFS_MIN (-32'sd4095)
`define TMA_OFFS_MAX 32'sd2000000000
`define TMA_RST_COUNT 13'h0001
`define TMA_RST_POINTS 13'h1000
`define TMA_RST_PERIOD 32'h00000001

`endif

//--- hdl/tma_pkg.sv
package tma_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DELAY = 2'b10,
		ST_STORE = 2'b11
	} tma_state_t;

	typedef enum logic [1:0] {
		FN_VOLT = 2'b00,
		FN_CURR = 2'b01,
		FN_AUX = 2'b10,
		FN_NONE = 2'b11
	} tma_func_t;

	typedef enum logic [1:0] {
		SL_POS = 2'b00,
		SL_NEG = 2'b01,
		SL_EITHER = 2'b10,
		SL_RSVD = 2'b11
	} tma_slope_t;

endpackage

//--- hdl/tma_trig_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tma_trig_if #(parameter int SW = 16);
	logic signed [SW-1:0] sample;
	logic tick;
	logic enable;
	logic signed [SW-1:0] level;
	logic [SW-1:0] hysteresis_band;
	logic [1:0] slope;
	logic fire;
	modport ctl (output sample, tick, enable, level, hysteresis_band, slope, input fire);
	modport qual (input sample, tick, enable, level, hysteresis_band, slope, output fire);
endinterface
`default_nettype wire

//--- hdl/tma_trig_qual.sv
`timescale 1ns/1ps
`default_nettype none
module tma_trig_qual import tma_pkg::*; #(parameter int SW = 16) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstnInt,
	// Trigger path
	tma_trig_if.qual tif
);
	logic lowSeen_reg, lowSeen_next;
	logic highSeen_reg, highSeen_next;
	logic fire_reg, fire_next;
	logic signed [SW+1:0] s, lvl, lo, hi;
	logic belowBand, aboveBand, riseOk, fallOk, posEn, negEn;

	// One level for both directions, band around it
	assign s = (SW+2)'(tif.sample); // [R05]
	assign lvl = (SW+2)'(tif.level);
	assign lo = lvl - (SW+2)'({2'b00, tif.hysteresis_band}); // [R03]
	assign hi = lvl + (SW+2)'({2'b00, tif.hysteresis_band});
	assign belowBand = s < lo;
	assign aboveBand = s > hi;
	assign posEn = (tif.slope == SL_POS) || (tif.slope == SL_EITHER); // [R04]
	assign negEn = (tif.slope == SL_NEG) || (tif.slope == SL_EITHER);
	// Crossing counts only after leaving the band on the far side
	assign riseOk = lowSeen_reg && (s >= lvl) && posEn; // [R22]
	assign fallOk = highSeen_reg && (s <= lvl) && negEn; // [R22]

	always_comb begin
		lowSeen_next = lowSeen_reg;
		highSeen_next = highSeen_reg;
		fire_next = 1'b0;
		if (!tif.enable) begin
			lowSeen_next = 1'b0;
			highSeen_next = 1'b0;
		end else if (tif.tick) begin
			fire_next = riseOk || fallOk; // [R03]
			if (riseOk || belowBand == 1'b0 && s >= lvl) begin
				lowSeen_next = 1'b0;
			end
			if (fallOk || aboveBand == 1'b0 && s <= lvl) begin
				highSeen_next = 1'b0;
			end
			if (belowBand) begin
				lowSeen_next = 1'b1;
			end
			if (aboveBand) begin
				highSeen_next = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			lowSeen_reg <= 1'b0;
			highSeen_reg <= 1'b0;
			fire_reg <= 1'b0;
		end else begin
			lowSeen_reg <= lowSeen_next;
			highSeen_reg <= highSeen_next;
			fire_reg <= fire_next;
		end
	end

	assign tif.fire = fire_reg;
endmodule
`default_nettype wire

//--- hdl/tma_acq.sv
// Notes on behaviour
// [R01] Exactly one sensing function must be chosen before arming.
// [R02] Immediate, common and group-execute bus triggers fire; immediate ignores source.
// [R03] Internal trigger uses level, edge direction and hysteresis band.
// [R04] Edge direction: positive only, negative only, or either.
// [R05] One trigger level serves both rising and falling crossings.
// [R06] Host finishes edge, level and band setup before arming.
// [R07] A result query while armed is held until acquisition completes.
// [R08] With completion reporting requested, completion sets event bit 0.
// [R09] Count above one gives that many ordered acquisitions per arm.
// [R10] Auxiliary voltmeter function allows only one acquisition per arm.
// [R11] Count times points above 4096 is an error.
// [R12] Sampling runs continuously from arming for pre-trigger data.
// [R13] Record offset is signed, -4095 to 2,000,000,000 points.
// [R14] Negative offset puts pre-trigger samples first; zero, all after.
// [R15] Positive offset delays storing by offset times sample period.
// [R16] Trigger before pre-trigger count is collected is ignored.
// [R17] Operation bit 5 is set while armed and waiting for trigger.
// [R18] Questionable bit 14 flags low current range overload.
// [R19] Idle after reset, abort or reset command; triggers ignored.
// [R20] Arm moves idle to armed; completion returns to idle.
// [R21] Trigger source selects bus or internal signal condition.
// [R22] Internal crossing qualifies only after leaving band on far side.
// [R23] Sample period is programmable per point.
`timescale 1ns/1ps
`default_nettype none
`include "tma_params.svh"
module tma_acq import tma_pkg::*; #(
	parameter int BUF_DEPTH = `TMA_BUF_DEPTH,
	parameter int SW = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// Sampled signals
	input wire logic [SW-1:0] sampleVolt,
	input wire logic [SW-1:0] sampleCurr,
	input wire logic [SW-1:0] auxVoltmeterInput,
	input wire logic lowRangeOverload,
	// Status
	output logic waitingForTriggerFlag,
	output logic resultReady
);
	localparam int AW = $clog2(BUF_DEPTH);
	localparam int PW = AW + 1;

	function automatic logic [AW-1:0] wrapAdd(input logic [AW-1:0] a, input logic [PW-1:0] b,
		input logic [PW-1:0] pts);
		logic [PW:0] sum;
		sum = {1'b0, 1'b0, a} + {1'b0, b};
		if (sum >= {1'b0, pts}) begin
			sum = sum - {1'b0, pts};
		end
		return sum[AW-1:0];
	endfunction

	logic [1:0] rstPipe;
	logic rstnInt;
	logic [SW-1:0] syncA [3];
	logic [SW-1:0] syncB [3];
	logic ovlA, ovlB;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rstPipe <= 2'b00;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstnInt = rstPipe[1];

	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			syncA <= '{default: '0};
			syncB <= '{default: '0};
			ovlA <= 1'b0;
			ovlB <= 1'b0;
		end else begin
			syncA <= '{sampleVolt, sampleCurr, auxVoltmeterInput};
			syncB <= syncA;
			ovlA <= lowRangeOverload;
			ovlB <= ovlA;
		end
	end

	tma_state_t state_reg, state_next;
	logic [1:0] func_reg;
	logic src_reg;
	logic [SW-1:0] level_reg, hysteresis_band_reg;
	logic [1:0] slope_reg;
	logic [PW-1:0] count_reg, points_reg;
	logic signed [31:0] offset_reg;
	logic [31:0] period_reg, perCnt_reg, delay_reg;
	logic [PW-1:0] li_reg, pre_reg, remain_reg, acq_reg;
	logic [AW-1:0] base_reg;
	logic [15:0] esr_reg;
	logic opcReq_reg, fetchPend_reg, dataValid_reg, ovld_reg;
	logic [AW-1:0] idxAcq_reg, idxPt_reg;
	logic [SW-1:0] bufQ_reg;
	logic [SW-1:0] mem [BUF_DEPTH];
	logic [AW-1:0] startMem [BUF_DEPTH];

	// Decode
	wire isCmd = regWr && regAddr == `TMA_A_CMD;
	wire cfgOpen = state_reg == ST_IDLE;
	wire cmdArm = isCmd && regWdata[`TMA_CMD_ARM];
	wire cmdAbort = isCmd && (regWdata[`TMA_CMD_ABORT] || regWdata[`TMA_CMD_RESET]);
	wire cmdImm = isCmd && regWdata[`TMA_CMD_IMM];
	wire cmdBus = isCmd && (regWdata[`TMA_CMD_TRG] || regWdata[`TMA_CMD_GET]);
	wire cmdOpc = isCmd && regWdata[`TMA_CMD_OPC];
	wire cmdFetch = isCmd && regWdata[`TMA_CMD_FETCH];
	wire [2*PW-1:0] product = count_reg * points_reg;
	wire [PW-1:0] preNeed = offset_reg < 0 ? PW'(-offset_reg) : '0;
	wire offsetOk = offset_reg >= `TMA_OFFS_MIN && offset_reg <= `TMA_OFFS_MAX // [R13]
		&& preNeed < points_reg;
	wire armOk = func_reg != FN_NONE // [R01]
		&& !(func_reg == FN_AUX && count_reg != PW'(1)) // [R10]
		&& product <= (2*PW)'(BUF_DEPTH) // [R11]
		&& count_reg != '0 && points_reg != '0 && offsetOk;
	wire armGo = cmdArm && !cmdAbort && cfgOpen && armOk; // [R20]
	wire armBad = cmdArm && cfgOpen && !armOk;
	wire tick = state_reg != ST_IDLE && perCnt_reg + 32'h1 >= period_reg; // [R23]
	wire [SW-1:0] sampleSel = func_reg == FN_CURR ? syncB[1] :
		func_reg == FN_AUX ? syncB[2] : syncB[0];
	wire preMet = pre_reg >= preNeed; // [R16]
	wire intFire;
	wire trig = cmdImm || (cmdBus && !src_reg) || (intFire && src_reg); // [R02] [R21]
	wire trigTaken = state_reg == ST_WAIT && trig && preMet;
	wire storeLast = state_reg == ST_STORE && tick && remain_reg == PW'(1);
	wire doneEvt = storeLast && acq_reg + PW'(1) == count_reg;
	wire writeMem = tick && (state_reg == ST_WAIT || state_reg == ST_STORE); // [R12]
	wire [AW-1:0] wrAddr = base_reg + li_reg[AW-1:0];
	wire [AW-1:0] recStart = wrapAdd(li_reg[AW-1:0], points_reg - preNeed, points_reg); // [R14]
	wire [AW-1:0] rdAddr = AW'(idxAcq_reg * points_reg) + wrapAdd(startMem[idxAcq_reg],
		PW'(idxPt_reg), points_reg);
	wire esrRead = regRd && regAddr == `TMA_A_ESR;
	wire fetchGo = fetchPend_reg && cfgOpen && dataValid_reg; // [R07]

	tma_trig_if #(.SW(SW)) tif ();
	assign tif.sample = sampleSel;
	assign tif.tick = tick;
	assign tif.enable = state_reg == ST_WAIT;
	assign tif.level = level_reg;
	assign tif.hysteresis_band = hysteresis_band_reg;
	assign tif.slope = slope_reg;
	assign intFire = tif.fire;

	tma_trig_qual #(.SW(SW)) u_qual (
		.mclk(mclk),
		.rstnInt(rstnInt),
		.tif(tif)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (armGo) begin
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (trigTaken) begin
					state_next = offset_reg > 0 ? ST_DELAY : ST_STORE;
				end
			end
			ST_DELAY: begin
				if (tick && delay_reg == 32'h1) begin
					state_next = ST_STORE; // [R15]
				end
			end
			ST_STORE: begin
				if (storeLast) begin
					state_next = doneEvt ? ST_IDLE : ST_WAIT; // [R09] [R20]
				end
			end
			default: state_next = ST_IDLE;
		endcase
		if (cmdAbort) begin
			state_next = ST_IDLE; // [R19]
		end
	end

	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Configuration, writable only while idle; buffer index writable at any time
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			func_reg <= FN_NONE;
			src_reg <= 1'b0;
			level_reg <= '0;
			hysteresis_band_reg <= '0;
			slope_reg <= SL_POS;
			count_reg <= `TMA_RST_COUNT;
			points_reg <= `TMA_RST_POINTS;
			offset_reg <= '0;
			period_reg <= `TMA_RST_PERIOD;
			idxAcq_reg <= '0;
			idxPt_reg <= '0;
		end else if (regWr) begin
			if (cfgOpen && regAddr == `TMA_A_FUNC) begin
				func_reg <= regWdata[1:0];
			end else if (cfgOpen && regAddr == `TMA_A_SRC) begin
				src_reg <= regWdata[0];
			end else if (cfgOpen && regAddr == `TMA_A_LEVEL) begin
				level_reg <= regWdata[SW-1:0];
			end else if (cfgOpen && regAddr == `TMA_A_HYSTERESIS_BAND) begin
				hysteresis_band_reg <= regWdata[SW-1:0];
			end else if (cfgOpen && regAddr == `TMA_A_SLOPE) begin
				slope_reg <= regWdata[1:0];
			end else if (cfgOpen && regAddr == `TMA_A_COUNT) begin
				count_reg <= regWdata[PW-1:0];
			end else if (cfgOpen && regAddr == `TMA_A_POINTS) begin
				points_reg <= regWdata[PW-1:0];
			end else if (cfgOpen && regAddr == `TMA_A_OFFSET) begin
				offset_reg <= regWdata;
			end else if (cfgOpen && regAddr == `TMA_A_PERIOD) begin
				period_reg <= regWdata;
			end else if (regAddr == `TMA_A_BUFIDX) begin
				idxAcq_reg <= regWdata[16+AW-1:16];
				idxPt_reg <= regWdata[AW-1:0];
			end
		end
	end

	// Acquisition datapath
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			perCnt_reg <= '0;
			li_reg <= '0;
			pre_reg <= '0;
			remain_reg <= '0;
			acq_reg <= '0;
			base_reg <= '0;
			delay_reg <= '0;
		end else begin
			perCnt_reg <= (tick || state_reg == ST_IDLE) ? 32'h0 : perCnt_reg + 32'h1;
			if (armGo) begin
				li_reg <= '0;
				pre_reg <= '0;
				acq_reg <= '0;
				base_reg <= '0;
			end else if (trigTaken) begin
				remain_reg <= points_reg - preNeed;
				delay_reg <= 32'(offset_reg);
				if (offset_reg >= 0) begin
					li_reg <= '0;
				end
			end else begin
				if (writeMem) begin
					li_reg <= PW'(wrapAdd(li_reg[AW-1:0], PW'(1), points_reg));
				end
				if (state_reg == ST_WAIT && tick && !preMet) begin
					pre_reg <= pre_reg + PW'(1);
				end
				if (state_reg == ST_DELAY && tick) begin
					delay_reg <= delay_reg - 32'h1;
				end
				if (state_reg == ST_STORE && tick) begin
					remain_reg <= remain_reg - PW'(1);
				end
				if (storeLast) begin
					acq_reg <= acq_reg + PW'(1);
					base_reg <= base_reg + points_reg[AW-1:0]; // [R09]
					li_reg <= '0;
					pre_reg <= '0;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (writeMem) begin
			mem[wrAddr] <= sampleSel;
		end
		if (trigTaken) begin
			startMem[acq_reg[AW-1:0]] <= offset_reg < 0 ? recStart : '0; // [R14]
		end
		bufQ_reg <= mem[rdAddr];
	end

	// Status and completion
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			esr_reg <= '0;
			opcReq_reg <= 1'b0;
			fetchPend_reg <= 1'b0;
			dataValid_reg <= 1'b0;
			ovld_reg <= 1'b0;
			waitingForTriggerFlag <= 1'b0;
			resultReady <= 1'b0;
		end else begin
			esr_reg <= (esrRead ? 16'h0 : esr_reg)
				| (16'(doneEvt && opcReq_reg) << `TMA_ESR_OPC) // [R08]
				| (16'(armBad) << `TMA_ESR_EXE); // [R11]
			opcReq_reg <= cmdAbort || doneEvt ? 1'b0 : (cmdOpc ? 1'b1 : opcReq_reg);
			fetchPend_reg <= cmdAbort || fetchGo ? 1'b0 : (cmdFetch ? 1'b1 : fetchPend_reg);
			dataValid_reg <= doneEvt ? 1'b1 : (armGo || cmdAbort ? 1'b0 : dataValid_reg);
			ovld_reg <= ovlB && func_reg == FN_CURR && state_reg != ST_IDLE; // [R18]
			waitingForTriggerFlag <= state_next == ST_WAIT; // [R17]
			resultReady <= fetchGo; // [R07]
		end
	end

	// Register read, answer in the next cycle
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			regRdata <= '0;
		end else if (regRd) begin
			if (regAddr == `TMA_A_FUNC) begin
				regRdata <= 32'(func_reg);
			end else if (regAddr == `TMA_A_SRC) begin
				regRdata <= 32'(src_reg);
			end else if (regAddr == `TMA_A_LEVEL) begin
				regRdata <= 32'(level_reg);
			end else if (regAddr == `TMA_A_HYSTERESIS_BAND) begin
				regRdata <= 32'(hysteresis_band_reg);
			end else if (regAddr == `TMA_A_SLOPE) begin
				regRdata <= 32'(slope_reg);
			end else if (regAddr == `TMA_A_COUNT) begin
				regRdata <= 32'(count_reg);
			end else if (regAddr == `TMA_A_POINTS) begin
				regRdata <= 32'(points_reg);
			end else if (regAddr == `TMA_A_OFFSET) begin
				regRdata <= offset_reg;
			end else if (regAddr == `TMA_A_PERIOD) begin
				regRdata <= period_reg;
			end else if (regAddr == `TMA_A_OPER) begin
				regRdata <= 32'(waitingForTriggerFlag) << `TMA_OPER_WTG; // [R17]
			end else if (regAddr == `TMA_A_QUES) begin
				regRdata <= 32'(ovld_reg) << `TMA_QUES_OVLD; // [R18]
			end else if (esrRead) begin
				regRdata <= 32'(esr_reg);
			end else if (regAddr == `TMA_A_FETCH) begin
				regRdata <= {30'h0, dataValid_reg && cfgOpen, fetchPend_reg};
			end else if (regAddr == `TMA_A_BUFDATA) begin
				regRdata <= 32'(bufQ_reg);
			end else begin
				regRdata <= 32'h0;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstnInt);

	property p_idle_ignore;
		state_reg == ST_IDLE && !armGo |=> state_reg == ST_IDLE;
	endproperty
	a_idle_ignore: assert property (p_idle_ignore) else $error("idle left without arm"); // [R19]

	property p_single_fn;
		state_reg != ST_IDLE |-> func_reg != FN_NONE;
	endproperty
	a_single_fn: assert property (p_single_fn) else $error("armed with no function"); // [R01]

	property p_imm;
		state_reg == ST_WAIT && cmdImm && preMet && !cmdAbort |=> state_reg inside {ST_DELAY, ST_STORE};
	endproperty
	a_imm: assert property (p_imm) else $error("immediate trigger not taken"); // [R02]

	property p_pre_ignore;
		state_reg == ST_WAIT && !preMet |=> state_reg inside {ST_WAIT, ST_IDLE};
	endproperty
	a_pre_ignore: assert property (p_pre_ignore) else $error("early trigger accepted"); // [R16]

	property p_aux_single;
		state_reg != ST_IDLE && func_reg == FN_AUX |-> count_reg == PW'(1);
	endproperty
	a_aux_single: assert property (p_aux_single) else $error("aux run with count above one"); // [R10]

	property p_capacity;
		state_reg != ST_IDLE |-> product <= (2*PW)'(BUF_DEPTH);
	endproperty
	a_capacity: assert property (p_capacity) else $error("record exceeds buffer"); // [R11]

	property p_opc;
		doneEvt && opcReq_reg && !esrRead |=> esr_reg[`TMA_ESR_OPC] && state_reg == ST_IDLE;
	endproperty
	a_opc: assert property (p_opc) else $error("completion bit not set"); // [R08]

	property p_wtg;
		##1 waitingForTriggerFlag == (state_reg == ST_WAIT);
	endproperty
	a_wtg: assert property (p_wtg) else $error("waiting flag wrong"); // [R17]

	property p_fetch_hold;
		resultReady |-> $past(state_reg) == ST_IDLE && dataValid_reg;
	endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("result before completion"); // [R07]

	property p_multi;
		storeLast && !doneEvt && !cmdAbort |=> state_reg == ST_WAIT;
	endproperty
	a_multi: assert property (p_multi) else $error("no wait for next trigger"); // [R09]

	c_done: cover property (armGo ##[1:1000] doneEvt);
	c_pre: cover property (trigTaken && offset_reg < 0);
	c_delay: cover property (state_reg == ST_DELAY ##1 state_reg == ST_STORE);
	c_multi: cover property (storeLast && !doneEvt);
endmodule
`default_nettype wire

//--- bench/tma_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "tma_params.svh"
module tma_host_model (
	// Clock
	input wire logic mclk,
	// Register port
	output logic [7:0] regAddr,
	output logic [31:0] regWdata,
	output logic regWr,
	output logic regRd
);
	initial begin
		regAddr = 8'hFF;
		regWdata = 32'h00000000;
		regWr = 1'b0;
		regRd = 1'b0;
	end

	// Released lines show the inverse of the last value
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
		regAddr <= ~a;
		regWdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		regAddr <= ~a;
	endtask

	// Writes the arm command; the internal trigger test calls it after edge, level and band are written
	task automatic arm();
		wr(`TMA_A_CMD, 32'h00000001 << `TMA_CMD_ARM);
	endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tma_params.svh"
module testbench import tma_pkg::*;;
	typedef struct {logic [31:0] d; logic [31:0] m;} tma_exp_t;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [15:0] sampleVolt = 16'h0000;
	logic [15:0] sampleCurr = 16'h0000;
	logic [15:0] auxVoltmeterInput = 16'h0000;
	logic lowRangeOverload = 1'b0;
	wire [7:0] regAddr;
	wire [31:0] regWdata;
	wire regWr;
	wire regRd;
	wire [31:0] regRdata;
	wire waitingForTriggerFlag;
	wire resultReady;
	tma_exp_t expQ[$];
	tma_exp_t cur;
	logic rdDly = 1'b0;
	int nMismatch = 0;
	int totalChecks = 0;
	int nReady = 0;
	logic [15:0] dA;
	logic [15:0] dB;
	int tFn[7] = '{3, 2, 0, 0, 0, 0, 0};
	int tCnt[7] = '{1, 2, 2, 1, 1, 1, 1};
	int tOff[7] = '{0, 0, 0, -4096, 2000000001, -4095, 2000000000};
	bit tOk[7] = '{0, 0, 0, 0, 0, 1, 1};
	int iSl[7] = '{0, 0, 1, 1, 0, 2, 2};
	int iV0[7] = '{50, 150, 150, 105, 95, 50, 150};
	int iV1[7] = '{150, 50, 50, 50, 150, 150, 50};
	bit iF[7] = '{1, 0, 1, 0, 0, 1, 1};
	int pOff[4] = '{20, 0, 5, 2};
	int pPer[4] = '{1, 1, 4, 1};
	bit pRdy[4] = '{0, 1, 0, 1};

	always #10 mclk = ~mclk;

	tma_host_model i_host (.mclk(mclk), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd));

	tma_acq #(.BUF_DEPTH(`TMA_BUF_DEPTH), .SW(16)) i_dut (.mclk(mclk), .rstn(rstn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .sampleVolt(sampleVolt), .sampleCurr(sampleCurr),
		.auxVoltmeterInput(auxVoltmeterInput), .lowRangeOverload(lowRangeOverload),
		.waitingForTriggerFlag(waitingForTriggerFlag), .resultReady(resultReady));

	task automatic tally_and_finish();
		if (nMismatch == 0 && totalChecks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
		totalChecks++;
		if ((g & m) !== (e & m)) begin
			nMismatch++;
			$display("unexpected at %0t: got %h want %h", $time, g & m, e & m);
		end
	endtask

	// Read data land in the cycle after the strobe
	always @(posedge mclk) begin
		if (rdDly) begin
			cur = expQ.pop_front();
			chk(regRdata, cur.d, cur.m);
		end
		if (resultReady === 1'b1) begin
			nReady++;
		end
		rdDly <= regRd;
	end

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		expQ.push_back('{e, m});
		i_host.rd(a);
	endtask

	task automatic cmd(input int b);
		i_host.wr(`TMA_A_CMD, 32'h00000001 << b);
	endtask

	task automatic cfg(input logic [31:0] fn, sr, cnt, pts, off, per);
		i_host.wr(`TMA_A_FUNC, fn);
		i_host.wr(`TMA_A_SRC, sr);
		i_host.wr(`TMA_A_COUNT, cnt);
		i_host.wr(`TMA_A_POINTS, pts);
		i_host.wr(`TMA_A_OFFSET, off);
		i_host.wr(`TMA_A_PERIOD, per);
	endtask

	task automatic waitFlag(input logic e, input int n);
		int i;
		for (i = 0; i < n && waitingForTriggerFlag !== e; i++) @(posedge mclk);
		chk({31'h0, waitingForTriggerFlag}, {31'h0, e}, 32'h00000001);
	endtask

	task automatic waitRes(input int c0, input int n);
		int i;
		for (i = 0; i < n && nReady == c0; i++) @(posedge mclk);
		chk(32'(nReady), 32'(c0 + 1), ALL);
	endtask

	task automatic bufChk(input logic [31:0] idx, input logic [15:0] e);
		i_host.wr(`TMA_A_BUFIDX, idx);
		repeat (3) @(posedge mclk);
		rd(`TMA_A_BUFDATA, {16'h0000, e}, 32'h0000FFFF);
	endtask

	initial begin
		repeat (40000) @(posedge mclk);
		nMismatch++;
		tally_and_finish();
	end

	initial begin
		int i;
		int c0;
		dA = 16'($urandom(3));
		dB = ~dA;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		repeat (5) @(posedge mclk);
		rd(`TMA_A_FUNC, 32'h00000003, ALL);
		rd(`TMA_A_COUNT, 32'h00000001, ALL);
		rd(`TMA_A_POINTS, 32'h00001000, ALL);
		rd(`TMA_A_OPER, 32'h00000000, ALL);
		rd(8'h40, 32'h00000000, ALL);
		// Arming refused or taken by settings
		for (i = 0; i < 7; i++) begin
			cfg(tFn[i], 0, tCnt[i], 32'h00001000, tOff[i], 1);
			i_host.arm();
			rd(`TMA_A_ESR, tOk[i] ? 32'h0 : 32'h10, 32'h00000010);
			rd(`TMA_A_OPER, tOk[i] ? 32'h20 : 32'h0, 32'h00000020);
			cmd(`TMA_CMD_ABORT);
		end
		// Bus triggers and source selection
		cfg(FN_VOLT, 1, 1, 4, 0, 1);
		i_host.arm();
		cmd(`TMA_CMD_TRG);
		rd(`TMA_A_OPER, 32'h00000020, 32'h00000020);
		cmd(`TMA_CMD_IMM);
		waitFlag(1'b0, 20);
		repeat (10) @(posedge mclk);
		i_host.wr(`TMA_A_SRC, 32'h00000000);
		for (i = `TMA_CMD_TRG; i <= `TMA_CMD_GET; i++) begin
			i_host.arm();
			waitFlag(1'b1, 4);
			cmd(i);
			waitFlag(1'b0, 20);
			repeat (10) @(posedge mclk);
		end
		// Pre-trigger record, early trigger dropped
		sampleVolt <= dA;
		cfg(FN_VOLT, 0, 1, 8, -7, 4);
		i_host.arm();
		cmd(`TMA_CMD_IMM);
		rd(`TMA_A_OPER, 32'h00000020, 32'h00000020);
		repeat (60) @(posedge mclk);
		cmd(`TMA_CMD_IMM);
		sampleVolt <= dB;
		c0 = nReady;
		cmd(`TMA_CMD_FETCH);
		waitRes(c0, 80);
		bufChk(32'h00000000, dA);
		bufChk(32'h00000006, dA);
		sampleVolt <= dA;
		i_host.wr(`TMA_A_OFFSET, -2);
		i_host.arm();
		repeat (60) @(posedge mclk);
		cmd(`TMA_CMD_IMM);
		sampleVolt <= dB;
		c0 = nReady;
		cmd(`TMA_CMD_FETCH);
		waitRes(c0, 80);
		bufChk(32'h00000001, dA);
		bufChk(32'h00000007, dB);
		// Two acquisitions per arm, fetch held meanwhile
		rd(`TMA_A_ESR, 32'h00000000, 32'h00000001);
		sampleVolt <= dA;
		cfg(FN_VOLT, 0, 2, 4, 0, 1);
		i_host.arm();
		cmd(`TMA_CMD_OPC);
		c0 = nReady;
		cmd(`TMA_CMD_FETCH);
		repeat (20) @(posedge mclk);
		rd(`TMA_A_FETCH, 32'h00000001, 32'h00000003);
		cmd(`TMA_CMD_IMM);
		waitFlag(1'b0, 20);
		waitFlag(1'b1, 40);
		chk(32'(nReady), 32'(c0), ALL);
		sampleVolt <= dB;
		repeat (5) @(posedge mclk);
		cmd(`TMA_CMD_IMM);
		waitRes(c0, 80);
		rd(`TMA_A_ESR, 32'h00000001, 32'h00000001);
		bufChk(32'h00000000, dA);
		bufChk(32'h00010003, dB);
		// Delay after trigger scales with offset and period
		for (i = 0; i < 4; i++) begin
			cfg(FN_VOLT, 0, 1, 2, pOff[i], pPer[i]);
			i_host.arm();
			cmd(`TMA_CMD_IMM);
			repeat (12) @(posedge mclk);
			rd(`TMA_A_FETCH, pRdy[i] ? 32'h2 : 32'h0, 32'h00000002);
			c0 = nReady;
			cmd(`TMA_CMD_FETCH);
			waitRes(c0, 80);
		end
		// Internal trigger on level, edge and band
		cfg(FN_VOLT, 1, 1, 2, 0, 1);
		i_host.wr(`TMA_A_LEVEL, 32'h00000064);
		i_host.wr(`TMA_A_HYSTERESIS_BAND, 32'h00000014);
		for (i = 0; i < 7; i++) begin
			i_host.wr(`TMA_A_SLOPE, iSl[i]);
			sampleVolt <= 16'(iV0[i]);
			repeat (8) @(posedge mclk);
			i_host.arm();
			repeat (8) @(posedge mclk);
			sampleVolt <= 16'(iV1[i]);
			repeat (20) @(posedge mclk);
			rd(`TMA_A_OPER, iF[i] ? 32'h0 : 32'h20, 32'h00000020);
			cmd(`TMA_CMD_ABORT);
		end
		// Low range overload in current function
		cfg(FN_CURR, 0, 1, 4, 0, 1);
		i_host.arm();
		lowRangeOverload <= 1'b1;
		repeat (5) @(posedge mclk);
		rd(`TMA_A_QUES, 32'h00004000, 32'h00004000);
		lowRangeOverload <= 1'b0;
		repeat (5) @(posedge mclk);
		rd(`TMA_A_QUES, 32'h00000000, 32'h00004000);
		repeat (4) @(posedge mclk);
		tally_and_finish();
	end
endmodule
`default_nettype wire
